// ---- hw/fes_host.sv ----
// Host-side controller issuing chip erase, erase and program suspend/resume
// and status reads to a parallel flash over its asynchronous pins.
// Assumes i_sect_erase_busy and i_prog_busy come from same-clock logic.
//
// Behaviour
// - Chip erase is six writes: AA/555, 55/2AA, 80/555, AA/555, 55/2AA, 10/555.
// - Hardware reset aborts erase; host must then reissue the full sequence.
// - Erase suspend is B0 to any address, only during sector erase.
// - Erase resume is 30 to any address; repeats ignored; re-suspend allowed.
// - Program resume leaves program suspend; repeats ignored.
// - Program suspend is B0 to any address.
// - Program resume is 30 to any address.
`timescale 1ns/100ps
`default_nettype none
`include "fes_defs.svh"

module fes_host
  import fes_pkg::*;
#(
  parameter int ADDR_W = `FES_ADDR_W,
  parameter int DATA_W = `FES_DATA_W
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // User command port
  input wire logic i_cmd_valid,
  input wire fes_cmd_t i_cmd,
  input wire logic [ADDR_W-1:0] i_addr,
  output logic o_cmd_ready,
  output logic o_cmd_done,
  output logic o_cmd_refused,
  input wire logic i_hw_reset_req,
  // Operations started elsewhere
  input wire logic i_sect_erase_busy,
  input wire logic i_prog_busy,
  // Controller status
  output fes_mode_t o_mode,
  output logic [`FES_STATUS_W-1:0] o_status_byte,
  output logic o_reissue_erase,
  // Flash pins
  output logic [ADDR_W-1:0] o_flash_addr,
  output logic [DATA_W-1:0] o_dq_out,
  output logic o_dq_oe_b,
  input wire logic [DATA_W-1:0] i_dq_in,
  output logic o_we_b,
  output logic o_oe_b,
  output logic o_ce_b,
  output logic o_flash_rst_b
);

  // ****************************************************
  // Timing counts
  // ****************************************************
  localparam logic [`FES_TIMER_W-1:0] ESUSP_CYC = `FES_TIMER_W'(`FES_US2CYC(`FES_T_ESUSP_US));
  localparam logic [`FES_TIMER_W-1:0] PSUSP_CYC = `FES_TIMER_W'(`FES_US2CYC(`FES_T_PSUSP_US));
  localparam logic [`FES_TIMER_W-1:0] POLL_CYC = `FES_TIMER_W'(`FES_US2CYC(`FES_T_POLL_US));
  localparam logic [`FES_TIMER_W-1:0] RP_CYC = `FES_TIMER_W'(`FES_NS2CYC(`FES_T_RP_NS));

  typedef struct packed {
    fes_state_t st;
    fes_cmd_t cmd;
    fes_mode_t mode;
    logic [2:0] step;
    logic [`FES_TIMER_W-1:0] timer;
    logic [ADDR_W-1:0] rd_addr;
    logic esusp_under;
    logic reissue;
    logic done;
    logic refused;
    logic rst_b;
    logic [`FES_STATUS_W-1:0] status;
  } fes_host_regs_t;

  fes_host_regs_t host_reg;
  fes_host_regs_t host_next;

  logic bus_start;
  logic bus_write;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic bus_done;
  logic [DATA_W-1:0] bus_rdata;
  logic cmd_legal;

  // ****************************************************
  // Command word table
  // ****************************************************
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input fes_cmd_t cmd,
                                                       input logic [2:0] step);
    logic [ADDR_W+DATA_W-1:0] w;
    w = {ADDR_W'(`FES_ANY_ADDR), `FES_RESUME_DATA};
    if (cmd == FES_CMD_CHIP_ERASE) begin
      unique case (step)
        3'h0, 3'h3: w = {ADDR_W'(`FES_UNLOCK1_ADDR), `FES_UNLOCK1_DATA};
        3'h1, 3'h4: w = {ADDR_W'(`FES_UNLOCK2_ADDR), `FES_UNLOCK2_DATA};
        3'h2: w = {ADDR_W'(`FES_UNLOCK1_ADDR), `FES_SETUP_DATA};
        default: w = {ADDR_W'(`FES_UNLOCK1_ADDR), `FES_CHIP_ERASE_DATA};
      endcase
    end else if (cmd == FES_CMD_ERASE_SUSP || cmd == FES_CMD_PROG_SUSP) begin
      w = {ADDR_W'(`FES_ANY_ADDR), `FES_SUSPEND_DATA};
    end else begin
      w = {ADDR_W'(`FES_ANY_ADDR), `FES_RESUME_DATA};
    end
    return w;
  endfunction : seq_word

  // ****************************************************
  // Command legality against the tracked mode
  // ****************************************************
  always_comb begin
    cmd_legal = 1'b0;
    unique case (i_cmd)
      FES_CMD_CHIP_ERASE: cmd_legal = (host_reg.mode == FES_MODE_READY) &&
                                      !i_sect_erase_busy && !i_prog_busy;
      FES_CMD_ERASE_SUSP: cmd_legal = (host_reg.mode == FES_MODE_READY) &&
                                      i_sect_erase_busy;
      FES_CMD_ERASE_RES: cmd_legal = (host_reg.mode == FES_MODE_ESUSP);
      FES_CMD_PROG_SUSP: cmd_legal = i_prog_busy &&
                                     (host_reg.mode != FES_MODE_PSUSP);
      FES_CMD_PROG_RES: cmd_legal = (host_reg.mode == FES_MODE_PSUSP);
      FES_CMD_STATUS: cmd_legal = 1'b1;
      default: cmd_legal = 1'b0;
    endcase
  end

  // No command is taken while a chip erase runs
  assign o_cmd_ready = (host_reg.st == FES_IDLE) && !i_hw_reset_req;

  // ****************************************************
  // Sequencer
  // ****************************************************
  always_comb begin
    host_next = host_reg;
    host_next.done = 1'b0;
    host_next.refused = 1'b0;
    bus_start = 1'b0;
    bus_write = 1'b1;
    {bus_addr, bus_wdata} = seq_word(host_reg.cmd, host_reg.step);
    unique case (host_reg.st)
      FES_IDLE: begin
        if (i_hw_reset_req) begin
          host_next.st = FES_RESET;
          host_next.timer = RP_CYC;
          host_next.rst_b = 1'b0;
        end else if (i_cmd_valid && !cmd_legal) begin
          host_next.refused = 1'b1;
        end else if (i_cmd_valid) begin
          host_next.cmd = i_cmd;
          host_next.rd_addr = i_addr;
          host_next.step = (i_cmd == FES_CMD_CHIP_ERASE) ? 3'h0 : `FES_SEQ_LAST;
          host_next.st = (i_cmd == FES_CMD_STATUS) ? FES_POLL : FES_ISSUE;
          if (i_cmd == FES_CMD_CHIP_ERASE) begin
            host_next.reissue = 1'b0;
          end
        end
      end
      FES_ISSUE: begin
        bus_start = 1'b1;
        host_next.st = FES_WAIT_WR;
      end
      FES_WAIT_WR: begin
        if (bus_done && host_reg.step != `FES_SEQ_LAST) begin
          host_next.step = host_reg.step + 3'h1;
          host_next.st = FES_ISSUE;
        end else if (bus_done) begin
          host_next.st = FES_SETTLE;
          unique case (host_reg.cmd)
            FES_CMD_CHIP_ERASE: begin
              host_next.mode = FES_MODE_CHIP;
              host_next.timer = POLL_CYC;
            end
            FES_CMD_ERASE_SUSP: host_next.timer = ESUSP_CYC;
            FES_CMD_PROG_SUSP: begin
              host_next.timer = PSUSP_CYC;
              host_next.esusp_under = (host_reg.mode == FES_MODE_ESUSP);
            end
            FES_CMD_PROG_RES: begin
              // Program resumes; an erase suspended beneath it stays so
              host_next.mode = host_reg.esusp_under ? FES_MODE_ESUSP :
                               FES_MODE_READY;
              host_next.st = FES_IDLE;
              host_next.done = 1'b1;
            end
            default: begin
              host_next.mode = FES_MODE_READY;
              host_next.st = FES_IDLE;
              host_next.done = 1'b1;
            end
          endcase
        end
      end
      FES_SETTLE: begin
        host_next.timer = host_reg.timer - 1'b1;
        if (i_hw_reset_req && host_reg.mode == FES_MODE_CHIP) begin
          // Erase dies with the reset pulse; flag the erase as lost
          host_next.st = FES_RESET;
          host_next.timer = RP_CYC;
          host_next.rst_b = 1'b0;
          host_next.reissue = 1'b1;
          host_next.mode = FES_MODE_READY;
        end else if (host_reg.timer <= `FES_TIMER_W'(1)) begin
          host_next.st = FES_POLL;
        end
      end
      FES_POLL: begin
        bus_start = 1'b1;
        bus_write = 1'b0;
        bus_addr = host_reg.rd_addr;
        host_next.st = FES_POLL_WAIT;
      end
      FES_POLL_WAIT: begin
        if (bus_done) begin
          host_next.status = bus_rdata[`FES_STATUS_W-1:0];
          host_next.st = FES_IDLE;
          host_next.done = 1'b1;
          unique case (host_reg.cmd)
            FES_CMD_CHIP_ERASE: begin
              if (bus_rdata[`FES_POLL_BIT]) begin
                host_next.mode = FES_MODE_READY;
              end else begin
                host_next.st = FES_SETTLE;
                host_next.timer = POLL_CYC;
                host_next.done = 1'b0;
              end
            end
            FES_CMD_ERASE_SUSP: host_next.mode = FES_MODE_ESUSP;
            FES_CMD_PROG_SUSP: host_next.mode = FES_MODE_PSUSP;
            default: host_next.mode = host_reg.mode;
          endcase
        end
      end
      FES_RESET: begin
        host_next.timer = host_reg.timer - 1'b1;
        if (host_reg.timer <= `FES_TIMER_W'(1)) begin
          host_next.rst_b = 1'b1;
          host_next.mode = FES_MODE_READY;
          host_next.esusp_under = 1'b0;
          host_next.st = FES_IDLE;
        end
      end
      default: begin
        host_next.st = FES_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      host_reg <= '{st: FES_IDLE, cmd: FES_CMD_STATUS, mode: FES_MODE_READY,
                    rst_b: 1'b1, default: '0};
    end else begin
      host_reg <= host_next;
    end
  end

  // ****************************************************
  // Bus cycle engine
  // ****************************************************
  fes_bus_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_bus (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_start(bus_start),
    .i_write(bus_write),
    .i_addr(bus_addr),
    .i_wdata(bus_wdata),
    .o_busy(),
    .o_done(bus_done),
    .o_rdata(bus_rdata),
    .o_flash_addr(o_flash_addr),
    .o_dq_out(o_dq_out),
    .o_dq_oe_b(o_dq_oe_b),
    .i_dq_in(i_dq_in),
    .o_we_b(o_we_b),
    .o_oe_b(o_oe_b),
    .o_ce_b(o_ce_b)
  );

  assign o_cmd_done = host_reg.done;
  assign o_cmd_refused = host_reg.refused;
  assign o_mode = host_reg.mode;
  assign o_status_byte = host_reg.status;
  assign o_reissue_erase = host_reg.reissue;
  assign o_flash_rst_b = host_reg.rst_b;

endmodule : fes_host

`default_nettype wire

// ---- hw/fes_defs.svh ----
// Constants for the erase / suspend command controller: bus command words,
// fixed addresses, status bit positions and timing figures.
// Assumes a word-wide flash bus and the controller clock on FES_CLK_MHZ.
`ifndef FES_DEFS_SVH
`define FES_DEFS_SVH

// ****************************************************
// Clock and conversions
// ****************************************************
`define FES_CLK_MHZ 10
`define FES_NS2CYC(t) ((((t) * `FES_CLK_MHZ) + 999) / 1000)
`define FES_US2CYC(t) ((t) * `FES_CLK_MHZ)

// ****************************************************
// Bus widths
// ****************************************************
`define FES_ADDR_W 24
`define FES_DATA_W 16
`define FES_STATUS_W 8
`define FES_TIMER_W 16
`define FES_BCNT_W 8

// ****************************************************
// Command cycle words
// ****************************************************
`define FES_UNLOCK1_ADDR 24'h000555
`define FES_UNLOCK2_ADDR 24'h0002aa
`define FES_ANY_ADDR 24'h000000
`define FES_UNLOCK1_DATA 16'h00aa
`define FES_UNLOCK2_DATA 16'h0055
`define FES_SETUP_DATA 16'h0080
`define FES_CHIP_ERASE_DATA 16'h0010
`define FES_SUSPEND_DATA 16'h00b0
`define FES_RESUME_DATA 16'h0030
`define FES_SEQ_LAST 3'h5
`define FES_POLL_BIT 7

// ****************************************************
// Timing figures
// ****************************************************
`define FES_T_WP_NS 50
`define FES_T_WPH_NS 30
`define FES_T_ACC_NS 110
`define FES_T_RP_NS 500
`define FES_T_ESUSP_US 20
`define FES_T_PSUSP_US 15
`define FES_T_POLL_US 10
`define FES_SYNC_CYC 2

`endif

// ---- hw/fes_pkg.sv ----
// Types shared by the erase / suspend command controller.
// Assumes fes_defs.svh is on the include path.
package fes_pkg;

  // ****************************************************
  // User commands and tracked device mode
  // ****************************************************
  typedef enum logic [2:0] {
    FES_CMD_CHIP_ERASE = 3'h0,
    FES_CMD_ERASE_SUSP = 3'h1,
    FES_CMD_ERASE_RES = 3'h2,
    FES_CMD_PROG_SUSP = 3'h3,
    FES_CMD_PROG_RES = 3'h4,
    FES_CMD_STATUS = 3'h5
  } fes_cmd_t;

  typedef enum logic [1:0] {
    FES_MODE_READY = 2'h0,
    FES_MODE_CHIP = 2'h1,
    FES_MODE_ESUSP = 2'h3,
    FES_MODE_PSUSP = 2'h2
  } fes_mode_t;

  // ****************************************************
  // State machines
  // ****************************************************
  typedef enum logic [2:0] {
    FES_IDLE = 3'h0,
    FES_ISSUE = 3'h1,
    FES_WAIT_WR = 3'h3,
    FES_SETTLE = 3'h2,
    FES_POLL = 3'h6,
    FES_POLL_WAIT = 3'h7,
    FES_RESET = 3'h5
  } fes_state_t;

  typedef enum logic [1:0] {
    FES_B_IDLE = 2'h0,
    FES_B_STROBE = 2'h1,
    FES_B_HOLD = 2'h3,
    FES_B_SPARE = 2'h2
  } fes_bus_state_t;

endpackage : fes_pkg

// ---- hw/fes_bus_cycle.sv ----
// One asynchronous flash bus cycle, write or read, timed in clock cycles.
// Assumes the caller starts a cycle only while o_busy is low.
`timescale 1ns/100ps
`default_nettype none
`include "fes_defs.svh"

module fes_bus_cycle
  import fes_pkg::*;
#(
  parameter int ADDR_W = `FES_ADDR_W,
  parameter int DATA_W = `FES_DATA_W
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Cycle request
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  // Flash pins
  output logic [ADDR_W-1:0] o_flash_addr,
  output logic [DATA_W-1:0] o_dq_out,
  output logic o_dq_oe_b,
  input wire logic [DATA_W-1:0] i_dq_in,
  output logic o_we_b,
  output logic o_oe_b,
  output logic o_ce_b
);

  // ****************************************************
  // Timing counts
  // ****************************************************
  localparam logic [`FES_BCNT_W-1:0] WP_CYC = `FES_BCNT_W'(`FES_NS2CYC(`FES_T_WP_NS));
  localparam logic [`FES_BCNT_W-1:0] WPH_CYC = `FES_BCNT_W'(`FES_NS2CYC(`FES_T_WPH_NS));
  // Sync delay added so the sampled word really is the pin level
  localparam logic [`FES_BCNT_W-1:0] ACC_CYC =
    `FES_BCNT_W'(`FES_NS2CYC(`FES_T_ACC_NS) + `FES_SYNC_CYC);

  typedef struct packed {
    fes_bus_state_t st;
    logic [`FES_BCNT_W-1:0] cnt;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic we_b;
    logic oe_b;
    logic ce_b;
    logic dq_oe_b;
    logic done;
  } fes_bus_regs_t;

  fes_bus_regs_t bus_reg;
  fes_bus_regs_t bus_next;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    bus_next = bus_reg;
    bus_next.done = 1'b0;
    bus_next.dq_s1 = i_dq_in;
    bus_next.dq_s2 = bus_reg.dq_s1;
    unique case (bus_reg.st)
      FES_B_IDLE: begin
        if (i_start) begin
          bus_next.st = FES_B_STROBE;
          bus_next.wr = i_write;
          bus_next.addr = i_addr;
          bus_next.wdata = i_wdata;
          bus_next.ce_b = 1'b0;
          bus_next.dq_oe_b = ~i_write;
          bus_next.we_b = ~i_write;
          bus_next.oe_b = i_write;
          bus_next.cnt = i_write ? WP_CYC : ACC_CYC;
        end
      end
      FES_B_STROBE: begin
        bus_next.cnt = bus_reg.cnt - 1'b1;
        if (bus_reg.cnt <= `FES_BCNT_W'(1)) begin
          // Data still driven on the rising write strobe
          bus_next.st = FES_B_HOLD;
          bus_next.we_b = 1'b1;
          bus_next.oe_b = 1'b1;
          bus_next.cnt = WPH_CYC;
          if (!bus_reg.wr) begin
            bus_next.rdata = bus_reg.dq_s2;
          end
        end
      end
      FES_B_HOLD: begin
        bus_next.cnt = bus_reg.cnt - 1'b1;
        if (bus_reg.cnt <= `FES_BCNT_W'(1)) begin
          bus_next.st = FES_B_IDLE;
          bus_next.ce_b = 1'b1;
          bus_next.dq_oe_b = 1'b1;
          bus_next.done = 1'b1;
        end
      end
      default: begin
        bus_next.st = FES_B_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_reg <= '{st: FES_B_IDLE, we_b: 1'b1, oe_b: 1'b1, ce_b: 1'b1,
                   dq_oe_b: 1'b1, default: '0};
    end else begin
      bus_reg <= bus_next;
    end
  end

  assign o_busy = (bus_reg.st != FES_B_IDLE);
  assign o_done = bus_reg.done;
  assign o_rdata = bus_reg.rdata;
  assign o_flash_addr = bus_reg.addr;
  assign o_dq_out = bus_reg.wdata;
  assign o_dq_oe_b = bus_reg.dq_oe_b;
  assign o_we_b = bus_reg.we_b;
  assign o_oe_b = bus_reg.oe_b;
  assign o_ce_b = bus_reg.ce_b;

endmodule : fes_bus_cycle

`default_nettype wire

// ---- tb/fes_host_monitor.sv ----
// Assertion checker for the flash erase and suspend host controller.
// Assumes it is bound to fes_host and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module fes_host_monitor
  import fes_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  // Clock, reset and requests
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_cmd_valid,
  input wire fes_cmd_t i_cmd,
  input wire logic i_sect_erase_busy,
  input wire logic i_prog_busy,
  // Controller outputs
  input wire logic o_cmd_ready,
  input wire logic o_cmd_refused,
  input wire fes_mode_t o_mode,
  input wire logic [ADDR_W-1:0] o_flash_addr,
  input wire logic [DATA_W-1:0] o_dq_out,
  input wire logic o_dq_oe_b,
  input wire logic o_we_b,
  input wire logic o_oe_b,
  input wire logic o_ce_b,
  input wire logic o_flash_rst_b
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  logic take;
  assign take = i_cmd_valid && o_cmd_ready;
  // ********
  // Bus cycle shapes and command word / refusal checks
  // ********
  sequence s_we_pulse;
    !o_we_b [*1] ##1 o_we_b;
  endsequence
  sequence s_rst_pulse;
    !o_flash_rst_b [*5] ##1 o_flash_rst_b;
  endsequence
  sequence s_word(logic [15:0] d);
    ##[1:30] ($fell(o_we_b) && o_dq_out == d);
  endsequence
  property p_we_pulse; $fell(o_we_b) |-> s_we_pulse; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe width wrong");
  property p_wr_frame; !o_we_b |-> !o_ce_b && !o_dq_oe_b && o_oe_b; endproperty
  a_wr_frame: assert property (p_wr_frame) else $error("write cycle framing wrong");
  property p_wr_stable; $rose(o_we_b) |-> $stable({o_flash_addr, o_dq_out}); endproperty
  a_wr_stable: assert property (p_wr_stable) else $error("word moved under strobe");
  property p_rd_frame; !o_oe_b |-> !o_ce_b && o_dq_oe_b && o_we_b; endproperty
  a_rd_frame: assert property (p_rd_frame) else $error("read cycle framing wrong");
  property p_chip_first;
    take && i_cmd == FES_CMD_CHIP_ERASE && o_mode == FES_MODE_READY && !i_sect_erase_busy
      && !i_prog_busy |-> ##[1:30] ($fell(o_we_b) && o_flash_addr == 24'h000555
      && o_dq_out == 16'h00aa);
  endproperty
  a_chip_first: assert property (p_chip_first) else $error("erase opening word wrong");
  property p_esusp_ref; take && i_cmd == FES_CMD_ERASE_SUSP && !i_sect_erase_busy
    |=> o_cmd_refused; endproperty
  a_esusp_ref: assert property (p_esusp_ref) else $error("stray erase suspend taken");
  property p_esusp_wr; take && i_cmd == FES_CMD_ERASE_SUSP && i_sect_erase_busy
    && o_mode == FES_MODE_READY |-> s_word(16'h00b0); endproperty
  a_esusp_wr: assert property (p_esusp_wr) else $error("erase suspend word missing");
  property p_eres_ref; take && i_cmd == FES_CMD_ERASE_RES && o_mode != FES_MODE_ESUSP
    |=> o_cmd_refused; endproperty
  a_eres_ref: assert property (p_eres_ref) else $error("stray erase resume taken");
  property p_pres_ref; take && i_cmd == FES_CMD_PROG_RES && o_mode != FES_MODE_PSUSP
    |=> o_cmd_refused; endproperty
  a_pres_ref: assert property (p_pres_ref) else $error("stray program resume taken");
  property p_psusp_wr; take && i_cmd == FES_CMD_PROG_SUSP && i_prog_busy
    && o_mode != FES_MODE_PSUSP |-> s_word(16'h00b0); endproperty
  a_psusp_wr: assert property (p_psusp_wr) else $error("program suspend word missing");
  property p_pres_wr; take && i_cmd == FES_CMD_PROG_RES && o_mode == FES_MODE_PSUSP
    |-> s_word(16'h0030); endproperty
  a_pres_wr: assert property (p_pres_wr) else $error("program resume word missing");
  property p_rst_pulse; $fell(o_flash_rst_b) |-> s_rst_pulse; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("flash reset pulse wrong");
endmodule : fes_host_monitor

bind fes_host fes_host_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) fes_host_monitor_i (
  .i_clock, .i_rst_b, .i_cmd_valid, .i_cmd, .i_sect_erase_busy, .i_prog_busy, .o_cmd_ready,
  .o_cmd_refused, .o_mode, .o_flash_addr, .o_dq_out, .o_dq_oe_b, .o_we_b, .o_oe_b, .o_ce_b,
  .o_flash_rst_b);
`default_nettype wire

// ---- tb/fes_flash_model.sv ----
// Behavioural flash: chip erase, erase and program suspend and resume.
// Assumes sector erase and program activity arrive as levels from the bench.
`timescale 1ns/100ps
`default_nettype none
module fes_flash_model #(
  parameter int ERASE_NS = 30000
) (
  // Host pins
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic i_we_b,
  input wire logic i_oe_b,
  input wire logic i_ce_b,
  input wire logic i_rst_b,
  // Activity begun elsewhere
  input wire logic i_sect_busy,
  input wire logic i_prog_busy,
  // Data lines towards the host
  output logic [15:0] o_dq
);
  logic [39:0] seq_tbl [6];
  int step;
  time erase_end;
  logic esusp;
  logic psusp;
  initial begin
    seq_tbl = '{40'h000555_00aa, 40'h0002aa_0055, 40'h000555_0080,
      40'h000555_00aa, 40'h0002aa_0055, 40'h000555_0010};
    step = 0;
    erase_end = 0;
    esusp = 1'b0;
    psusp = 1'b0;
    o_dq = 16'h5a5a;
  end
  always @(negedge i_rst_b) begin
    step = 0;
    erase_end = $time;
    esusp = 1'b0;
    psusp = 1'b0;
  end
  // Words land on the strobe's rising edge
  always @(posedge i_we_b) begin
    if (!i_ce_b && i_rst_b && $time >= erase_end) begin
      if ({i_addr, i_data} == seq_tbl[step]) begin
        step = (step == 5) ? 0 : step + 1;
        if (step == 0) erase_end = $time + ERASE_NS;
      end else begin
        step = ({i_addr, i_data} == seq_tbl[0]) ? 1 : 0;
        if (i_data == 16'h00b0 && i_prog_busy) psusp = 1'b1;
        else if (i_data == 16'h00b0 && i_sect_busy) esusp = 1'b1;
        if (i_data == 16'h0030 && psusp) psusp = 1'b0;
        else if (i_data == 16'h0030) esusp = 1'b0;
      end
    end
  end
  always @(negedge i_oe_b) begin
    #60;
    if (!i_ce_b) o_dq = esusp ? 16'h0080 :
      (($time < erase_end) ? 16'h0000 : 16'hffff);
  end
  // Released lines flip so a stale word never passes for data
  always @(posedge i_oe_b) o_dq = ~o_dq;
endmodule : fes_flash_model
`default_nettype wire

// ---- tb/fes_host_tb_top.sv ----
// Self-checking bench for the flash erase and suspend host controller.
// Assumes the behavioural flash model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module fes_host_tb_top
  import fes_pkg::*;
;
  logic i_clock, i_rst_b, i_cmd_valid, i_hw_reset_req, i_sect_erase_busy, i_prog_busy;
  logic o_cmd_ready, o_cmd_done, o_cmd_refused, o_reissue_erase;
  logic o_dq_oe_b, o_we_b, o_oe_b, o_ce_b, o_flash_rst_b;
  fes_cmd_t i_cmd;
  fes_mode_t o_mode;
  logic [23:0] i_addr, o_flash_addr;
  logic [15:0] o_dq_out, dq_in, flash_dq;
  logic [7:0] o_status_byte;
  logic [39:0] wq [$];
  int bad_count, total_checks;
  fes_host fes_host_i (.i_clock, .i_rst_b, .i_cmd_valid, .i_cmd, .i_addr, .o_cmd_ready,
    .o_cmd_done, .o_cmd_refused, .i_hw_reset_req, .i_sect_erase_busy, .i_prog_busy, .o_mode,
    .o_status_byte, .o_reissue_erase, .o_flash_addr, .o_dq_out, .o_dq_oe_b, .i_dq_in(dq_in),
    .o_we_b, .o_oe_b, .o_ce_b, .o_flash_rst_b);
  fes_flash_model fes_flash_model_i (.i_addr(o_flash_addr), .i_data(o_dq_out), .i_we_b(o_we_b),
    .i_oe_b(o_oe_b), .i_ce_b(o_ce_b), .i_rst_b(o_flash_rst_b), .i_sect_busy(i_sect_erase_busy),
    .i_prog_busy(i_prog_busy), .o_dq(flash_dq));
  assign dq_in = o_dq_oe_b ? flash_dq : o_dq_out;
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  always @(posedge o_we_b) if (!o_ce_b) wq.push_back({o_flash_addr, o_dq_out});
  // ********
  // Helpers
  // ********
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask : tick
  task automatic run(input fes_cmd_t c, input logic rf);
    int n;
    n = 0;
    tick(1);
    while (o_cmd_ready !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    i_cmd = c;
    i_cmd_valid = 1'b1;
    tick(1);
    i_cmd_valid = 1'b0;
    while (o_cmd_done !== 1'b1 && o_cmd_refused !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    chk("answer", o_cmd_done | o_cmd_refused, 1'b1);
    chk("refused", o_cmd_refused, rf);
  endtask : run
  task automatic words(input logic [39:0] e [$], input logic with_addr);
    chk("word count", 24'(wq.size()), 24'(e.size()));
    foreach (e[i]) begin
      if (i < wq.size()) begin
        chk("word data", {8'h00, wq[i][15:0]}, {8'h00, e[i][15:0]});
        if (with_addr) chk("word addr", wq[i][39:16], e[i][39:16]);
      end
    end
    wq.delete();
  endtask : words
  // ********
  // Scenarios
  // ********
  task automatic t_chip();
    run(FES_CMD_CHIP_ERASE, 1'b0);
    words('{40'h000555_00aa, 40'h0002aa_0055, 40'h000555_0080, 40'h000555_00aa,
      40'h0002aa_0055, 40'h000555_0010}, 1'b1);
    chk("mode", o_mode, FES_MODE_READY);
    chk("status", o_status_byte, 8'hff);
    chk("reissue", o_reissue_erase, 1'b0);
  endtask : t_chip
  task automatic t_abort();
    int n;
    n = 0;
    tick(1);
    i_cmd = FES_CMD_CHIP_ERASE;
    i_cmd_valid = 1'b1;
    tick(1);
    i_cmd_valid = 1'b0;
    while (wq.size() < 6 && n < 900) begin
      tick(1);
      n++;
    end
    chk("ready in erase", o_cmd_ready, 1'b0);
    i_hw_reset_req = 1'b1;
    while (o_flash_rst_b !== 1'b0 && n < 900) begin
      tick(1);
      n++;
    end
    i_hw_reset_req = 1'b0;
    while (o_cmd_ready !== 1'b1 && n < 900) begin
      tick(1);
      n++;
    end
    chk("mode", o_mode, FES_MODE_READY);
    chk("reissue", o_reissue_erase, 1'b1);
    wq.delete();
    t_chip();
  endtask : t_abort
  task automatic t_esusp();
    run(FES_CMD_ERASE_SUSP, 1'b1);
    i_sect_erase_busy = 1'b1;
    run(FES_CMD_CHIP_ERASE, 1'b1);
    run(FES_CMD_ERASE_SUSP, 1'b0);
    chk("mode", o_mode, FES_MODE_ESUSP);
    chk("status", o_status_byte, 8'h80);
    run(FES_CMD_PROG_SUSP, 1'b1);
    i_prog_busy = 1'b1;
    run(FES_CMD_PROG_SUSP, 1'b0);
    chk("mode", o_mode, FES_MODE_PSUSP);
    run(FES_CMD_PROG_RES, 1'b0);
    chk("mode", o_mode, FES_MODE_ESUSP);
    i_prog_busy = 1'b0;
    run(FES_CMD_ERASE_RES, 1'b0);
    run(FES_CMD_ERASE_RES, 1'b1);
    run(FES_CMD_ERASE_SUSP, 1'b0);
    run(FES_CMD_ERASE_RES, 1'b0);
    chk("mode", o_mode, FES_MODE_READY);
    words('{40'h00b0, 40'h00b0, 40'h0030, 40'h0030, 40'h00b0, 40'h0030}, 1'b0);
    i_sect_erase_busy = 1'b0;
  endtask : t_esusp
  task automatic t_prog();
    run(FES_CMD_PROG_RES, 1'b1);
    i_prog_busy = 1'b1;
    run(FES_CMD_PROG_SUSP, 1'b0);
    chk("mode", o_mode, FES_MODE_PSUSP);
    run(FES_CMD_PROG_RES, 1'b0);
    run(FES_CMD_PROG_RES, 1'b1);
    run(FES_CMD_PROG_SUSP, 1'b0);
    run(FES_CMD_PROG_RES, 1'b0);
    chk("mode", o_mode, FES_MODE_READY);
    words('{40'h00b0, 40'h0030, 40'h00b0, 40'h0030}, 1'b0);
    i_prog_busy = 1'b0;
    run(FES_CMD_STATUS, 1'b0);
    chk("status", o_status_byte, 8'hff);
  endtask : t_prog
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    bad_count = 0;
    total_checks = 0;
    i_rst_b = 1'b0;
    i_cmd_valid = 1'b0;
    i_cmd = FES_CMD_STATUS;
    i_addr = 24'h000555;
    i_hw_reset_req = 1'b0;
    i_sect_erase_busy = 1'b0;
    i_prog_busy = 1'b0;
    tick(10);
    i_rst_b = 1'b1;
    t_chip();
    t_abort();
    t_esusp();
    t_prog();
    test_done();
  end
  // Whole run is a few thousand cycles; this cuts a hang
  initial begin
    #2000000;
    bad_count++;
    test_done();
  end
endmodule : fes_host_tb_top
`default_nettype wire
